// ### adc_calibration_correction.sv
`timescale 1ns/1ps
// Summary of operation
// - System offset is 24-bit two's complement, read/write, reset zero.
// - Coefficients and results shift across the serial port MSB first.
// - System calibration writes internal storage, never the user system coefficients.
// - Self calibration writes internal storage, never the user self coefficients.
// - Readback select 1 returns user value, 0 returns internal value; here 0 gives the internal value only while conversion_active_i is set.
// - Subtract system offset unless disable_system_offset is set.
// - System offset follows self corrections, precedes system gain and scaling.
// - Writes to system offset ignored during system offset calibration.
// - System gain is unsigned 24-bit, read/write, reset 0x7FFFFF.
// - Multiply by system gain unless disable_system_gain is set.
// - Writes to system gain ignored during system gain calibration.
// - Self offset subtracted first unless disable_self_offset is set.
// - Writes to self coefficients ignored during self calibration.
// - Self gain resets 0xBF851B and scales before system corrections.
// - Six 24-bit per-channel result registers, reset zero.
// - Host writes to result registers have no effect.
// - Unipolar results are always offset binary.
// - Bipolar results offset binary if format set, else two's complement.
// - Out-of-range results saturate to format limits.
module adc_calibration_correction (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Raw sample from the modulator/filter.
  input wire logic sample_valid_i,
  input wire logic [2:0] sample_channel_i,
  input wire logic [23:0] sample_data_i,
  // Mode bits from the control registers.
  input wire logic conversion_active_i,
  input wire logic unipolar_i,
  input wire logic output_format_i,
  input wire logic readback_select_i,
  input wire logic disable_system_offset_i,
  input wire logic disable_system_gain_i,
  input wire logic disable_self_offset_i,
  input wire logic disable_self_gain_i,
  // Calibration engine status and results.
  input wire logic sys_offset_cal_busy_i,
  input wire logic sys_gain_cal_busy_i,
  input wire logic self_cal_busy_i,
  input wire logic cal_store_i,
  input wire logic [2:0] cal_store_sel_i,
  input wire logic [23:0] cal_store_data_i,
  // Serial host access: bit-serial, framed by access_start_i.
  input wire logic access_start_i,
  input wire logic access_write_i,
  input wire logic [2:0] access_sel_i,
  input wire logic [2:0] access_channel_i,
  input wire logic shift_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic access_done_o,
  output logic result_valid_o
);
  localparam int BIT_CNT_W = 5;
  localparam logic [4:0] LAST_BIT = 5'h17;

  typedef struct packed {
    logic [23:0] sys_off;
    logic [23:0] sys_gain;
    logic [23:0] self_off;
    logic [23:0] self_gain;
    logic [23:0] int_sys_off;
    logic [23:0] int_sys_gain;
    logic [23:0] int_self_off;
    logic [23:0] int_self_gain;
    logic [2:0] pend_ch;
    logic [23:0] shreg;
    logic active;
    logic wr;
    logic [2:0] sel;
    logic [BIT_CNT_W-1:0] cnt;
    logic sdo;
    logic done;
    logic rvalid;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;
  logic rst_n_sync;
  logic [23:0] rd_word;
  logic [23:0] mem_rdata;
  logic mem_we;

  corr_if cif ();

  // Released reset: the pipeline and registers below use this copy.
  logic [1:0] rsync_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rsync_ff <= 2'h0;
    else rsync_ff <= {rsync_ff[0], 1'b1};
  end
  assign rst_n_sync = rsync_ff[1];

  // Internal coefficients feed the datapath; user values are only a seed.
  assign cif.in_valid = sample_valid_i;
  assign cif.raw = sample_data_i;
  assign cif.sys_off = st_ff.int_sys_off;
  assign cif.sys_gain = st_ff.int_sys_gain;
  assign cif.self_off = st_ff.int_self_off;
  assign cif.self_gain = st_ff.int_self_gain;
  assign cif.dis_sys_off = disable_system_offset_i;
  assign cif.dis_sys_gain = disable_system_gain_i;
  assign cif.dis_self_off = disable_self_offset_i;
  assign cif.dis_self_gain = disable_self_gain_i;
  assign cif.unipolar = unipolar_i;
  assign cif.offset_binary = output_format_i;

  corr_datapath u_dp (
    .clk_i(clk_i),
    .rst_n_i(rst_n_sync),
    .c(cif.dp)
  );

  // Result storage lives in its own memory; the write port is the datapath only.
  assign mem_we = cif.out_valid;
  result_mem #(.WIDTH(24), .DEPTH(cal_pkg::NUM_CH)) u_mem (
    .clk_i(clk_i),
    .rst_n_i(rst_n_sync),
    .we_i(mem_we),
    .waddr_i(st_ff.pend_ch),
    .wdata_i(cif.result),
    .raddr_i(access_channel_i),
    .rdata_o(mem_rdata)
  );

  // Readback mux: internal copies only while converting, else the user value.
  always_comb begin
    logic internal;
    internal = !readback_select_i && conversion_active_i;
    unique case (access_sel_i)
      cal_pkg::SEL_SYS_OFFSET: rd_word = internal ? st_ff.int_sys_off : st_ff.sys_off;
      cal_pkg::SEL_SYS_GAIN: rd_word = internal ? st_ff.int_sys_gain : st_ff.sys_gain;
      cal_pkg::SEL_SELF_OFFSET: rd_word = internal ? st_ff.int_self_off : st_ff.self_off;
      cal_pkg::SEL_SELF_GAIN: rd_word = internal ? st_ff.int_self_gain : st_ff.self_gain;
      default: rd_word = mem_rdata;
    endcase
  end

  always_comb begin
    logic blocked;
    blocked = 1'b0;
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.rvalid = cif.out_valid;
    // Channel tag is one register, loaded from each valid sample and held until the next one.
    if (sample_valid_i) nxt_st.pend_ch = sample_channel_i;

    // Calibration results land only in the internal copies.
    if (cal_store_i) begin
      unique case (cal_store_sel_i)
        cal_pkg::SEL_SYS_OFFSET: nxt_st.int_sys_off = cal_store_data_i;
        cal_pkg::SEL_SYS_GAIN: nxt_st.int_sys_gain = cal_store_data_i;
        cal_pkg::SEL_SELF_OFFSET: nxt_st.int_self_off = cal_store_data_i;
        cal_pkg::SEL_SELF_GAIN: nxt_st.int_self_gain = cal_store_data_i;
        default: ;
      endcase
    end

    // Serial frame: load on start, shift one bit per shift_i, MSB first.
    if (access_start_i) begin
      nxt_st.active = 1'b1;
      nxt_st.wr = access_write_i;
      nxt_st.sel = access_sel_i;
      nxt_st.cnt = '0;
      nxt_st.shreg = access_write_i ? 24'h000000 : rd_word;
      nxt_st.sdo = access_write_i ? 1'b0 : rd_word[23];
    end else if (st_ff.active && shift_i) begin
      nxt_st.shreg = {st_ff.shreg[22:0], sdi_i};
      nxt_st.sdo = st_ff.shreg[22];
      nxt_st.cnt = st_ff.cnt + 5'h01;
      if (st_ff.cnt == LAST_BIT) begin
        nxt_st.active = 1'b0;
        nxt_st.done = 1'b1;
        if (st_ff.wr) begin
          // A write during the matching calibration is simply lost.
          unique case (st_ff.sel)
            cal_pkg::SEL_SYS_OFFSET: begin
              blocked = sys_offset_cal_busy_i;
              if (!blocked) nxt_st.sys_off = {st_ff.shreg[22:0], sdi_i};
              if (!blocked) nxt_st.int_sys_off = {st_ff.shreg[22:0], sdi_i};
            end
            cal_pkg::SEL_SYS_GAIN: begin
              blocked = sys_gain_cal_busy_i;
              if (!blocked) nxt_st.sys_gain = {st_ff.shreg[22:0], sdi_i};
              if (!blocked) nxt_st.int_sys_gain = {st_ff.shreg[22:0], sdi_i};
            end
            cal_pkg::SEL_SELF_OFFSET: begin
              blocked = self_cal_busy_i;
              if (!blocked) nxt_st.self_off = {st_ff.shreg[22:0], sdi_i};
              if (!blocked) nxt_st.int_self_off = {st_ff.shreg[22:0], sdi_i};
            end
            cal_pkg::SEL_SELF_GAIN: begin
              blocked = self_cal_busy_i;
              if (!blocked) nxt_st.self_gain = {st_ff.shreg[22:0], sdi_i};
              if (!blocked) nxt_st.int_self_gain = {st_ff.shreg[22:0], sdi_i};
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Reset values of coefficients match the documented defaults.
  always_ff @(posedge clk_i or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      st_ff <= '0;
      st_ff.sys_off <= cal_pkg::SYS_OFFSET_RST;
      st_ff.sys_gain <= cal_pkg::SYS_GAIN_RST;
      st_ff.self_off <= cal_pkg::SELF_OFFSET_RST;
      st_ff.self_gain <= cal_pkg::SELF_GAIN_RST;
      st_ff.int_sys_off <= cal_pkg::SYS_OFFSET_RST;
      st_ff.int_sys_gain <= cal_pkg::SYS_GAIN_RST;
      st_ff.int_self_off <= cal_pkg::SELF_OFFSET_RST;
      st_ff.int_self_gain <= cal_pkg::SELF_GAIN_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sdo_o = st_ff.sdo;
  assign access_done_o = st_ff.done;
  assign result_valid_o = st_ff.rvalid;
endmodule : adc_calibration_correction

// ### cal_pkg.sv
package cal_pkg;
  localparam int DATA_W = 24;
  localparam int NUM_CH = 6;
  localparam int CH_W = 3;
  localparam int GAIN_SHIFT = 23;
  // Coefficient and result selectors used on the host access port.
  localparam logic [2:0] SEL_SYS_OFFSET = 3'h0;
  localparam logic [2:0] SEL_SYS_GAIN = 3'h1;
  localparam logic [2:0] SEL_SELF_OFFSET = 3'h2;
  localparam logic [2:0] SEL_SELF_GAIN = 3'h3;
  localparam logic [2:0] SEL_RESULT = 3'h4;
  // Reset values.
  localparam logic [23:0] SYS_OFFSET_RST = 24'h000000;
  localparam logic [23:0] SYS_GAIN_RST = 24'h7FFFFF;
  localparam logic [23:0] SELF_OFFSET_RST = 24'h000000;
  localparam logic [23:0] SELF_GAIN_RST = 24'hBF851B;
  localparam logic [23:0] RESULT_RST = 24'h000000;
  // Code limits of the output formats.
  localparam logic [23:0] TWOS_MAX = 24'h7FFFFF;
  localparam logic [23:0] TWOS_MIN = 24'h800000;
  localparam logic [23:0] MIDSCALE = 24'h800000;
endpackage : cal_pkg

// ### corr_if.sv
`timescale 1ns/1ps
// Carries one raw sample into the correction pipeline and the corrected code out.
interface corr_if;
  logic in_valid;
  logic signed [23:0] raw;
  logic [23:0] sys_off;
  logic [23:0] sys_gain;
  logic [23:0] self_off;
  logic [23:0] self_gain;
  logic dis_sys_off;
  logic dis_sys_gain;
  logic dis_self_off;
  logic dis_self_gain;
  logic unipolar;
  logic offset_binary;
  logic out_valid;
  logic [23:0] result;
  modport src (output in_valid, raw, sys_off, sys_gain, self_off, self_gain, dis_sys_off,
               dis_sys_gain, dis_self_off, dis_self_gain, unipolar, offset_binary,
               input out_valid, result);
  modport dp (input in_valid, raw, sys_off, sys_gain, self_off, self_gain, dis_sys_off,
              dis_sys_gain, dis_self_off, dis_self_gain, unipolar, offset_binary,
              output out_valid, result);
endinterface : corr_if

// ### corr_datapath.sv
`timescale 1ns/1ps
// Two-stage correction: self corrections, then system corrections and formatting.
module corr_datapath (
  input wire logic clk_i,
  input wire logic rst_n_i,
  corr_if.dp c
);
  typedef struct packed {
    logic v1;
    logic signed [26:0] mid;
    logic v2;
    logic [23:0] res;
  } dp_state_t;

  dp_state_t st_ff;
  dp_state_t nxt_st;

  // Clamp a wide signed value into a signed 27-bit working range.
  function automatic logic signed [26:0] clamp27(input logic signed [51:0] v);
    logic signed [51:0] hi;
    logic signed [51:0] lo;
    hi = 52'sh00000003FFFFFF;
    lo = -52'sh00000004000000;
    if (v > hi) clamp27 = hi[26:0];
    else if (v < lo) clamp27 = lo[26:0];
    else clamp27 = v[26:0];
  endfunction : clamp27

  // Working values are kept a few bits wide so intermediate overrange saturates late.
  always_comb begin
    logic signed [26:0] a;
    logic signed [51:0] p;
    logic signed [26:0] b;
    logic signed [27:0] s;
    logic [23:0] code;
    a = '0;
    p = '0;
    b = '0;
    s = '0;
    code = '0;
    nxt_st = st_ff;
    nxt_st.v1 = c.in_valid;
    nxt_st.v2 = st_ff.v1;
    a = 27'(c.raw);
    if (!c.dis_self_off) a = 27'(a - 27'($signed(c.self_off)));
    if (!c.dis_self_gain) begin
      p = 52'(a) * $signed({28'h0, c.self_gain});
      a = clamp27(p >>> cal_pkg::GAIN_SHIFT);
    end
    if (c.in_valid) nxt_st.mid = a;
    b = st_ff.mid;
    if (!c.dis_sys_off) b = 27'(b - 27'($signed(c.sys_off)));
    if (!c.dis_sys_gain) begin
      p = 52'(b) * $signed({28'h0, c.sys_gain});
      b = clamp27(p >>> cal_pkg::GAIN_SHIFT);
    end
    // Unipolar doubles after all corrections; this also maps to offset binary.
    s = c.unipolar ? 28'(b) * 28'sh2 : 28'(b);
    if (s > 28'sh07FFFFF) code = cal_pkg::TWOS_MAX;
    else if (s < -28'sh0800000) code = cal_pkg::TWOS_MIN;
    else code = s[23:0];
    if (c.unipolar || c.offset_binary) code = code ^ cal_pkg::MIDSCALE;
    if (st_ff.v1) nxt_st.res = code;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  assign c.out_valid = st_ff.v2;
  assign c.result = st_ff.res;
endmodule : corr_datapath

// ### result_mem.sv
`timescale 1ns/1ps
// Per-channel result store with registered read data.
module result_mem #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 6
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [2:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [2:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] rd_ff;

  // One register per channel, cleared at reset.
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ch
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) mem_ff[g] <= '0;
        else if (we_i && waddr_i == 3'(g)) mem_ff[g] <= wdata_i;
      end
    end
  endgenerate

  // Out-of-range channel numbers read as zero.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rd_ff <= '0;
    else rd_ff <= (int'(raddr_i) < DEPTH) ? mem_ff[raddr_i] : '0;
  end
  assign rdata_o = rd_ff;
endmodule : result_mem

// ### adc_cal_checker.sv
`timescale 1ns/1ps
// Watches the result and frame handshakes at the top ports.
module adc_cal_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sample_valid_i,
  input wire logic access_start_i,
  input wire logic shift_i,
  input wire logic sdo_o,
  input wire logic access_done_o,
  input wire logic result_valid_o
);
  logic [4:0] cnt_ff;
  logic in_frame_ff;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Shift count of the open frame; a new start restarts it, so an abort is tracked too.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 5'h00;
      in_frame_ff <= 1'b0;
    end else if (access_start_i) begin
      cnt_ff <= 5'h00;
      in_frame_ff <= 1'b1;
    end else if (in_frame_ff && shift_i) begin
      cnt_ff <= cnt_ff + 5'h01;
      in_frame_ff <= (cnt_ff != 5'h17);
    end
  end
  sequence last_shift_s;
    in_frame_ff && shift_i && !access_start_i && cnt_ff == 5'h17;
  endsequence
  sequence done_pulse_s;
    access_done_o ##1 !access_done_o;
  endsequence
  valid_after_sample_a: assert property (sample_valid_i |-> ##3 result_valid_o)
    else $error("result_valid_o late");
  valid_has_cause_a: assert property (result_valid_o |-> $past(sample_valid_i, 3))
    else $error("result_valid_o without sample");
  valid_single_a: assert property (result_valid_o |=> !result_valid_o)
    else $error("result_valid_o too long");
  done_after_last_a: assert property (last_shift_s |=> done_pulse_s)
    else $error("access_done_o missing after last shift");
  done_has_shift_a: assert property (access_done_o |-> $past(shift_i) && $past(in_frame_ff))
    else $error("access_done_o without shift");
  no_early_done_a: assert property (in_frame_ff && cnt_ff < 5'h17 |=> !access_done_o)
    else $error("access_done_o early");
  sdo_holds_a: assert property (in_frame_ff && !shift_i && !access_start_i |=> $stable(sdo_o))
    else $error("sdo_o moved without shift");
  start_no_done_a: assert property (access_start_i |=> !access_done_o)
    else $error("access_done_o after start");
endmodule : adc_cal_checker

bind adc_calibration_correction adc_cal_checker u_chk (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .sample_valid_i(sample_valid_i),
  .access_start_i(access_start_i),
  .shift_i(shift_i),
  .sdo_o(sdo_o),
  .access_done_o(access_done_o),
  .result_valid_o(result_valid_o)
);

// ### host_model.sv
`timescale 1ns/1ps
// Serial host: runs one 24-bit access frame at a time.
module host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  input wire logic done_i,
  output logic start_o,
  output logic write_o,
  output logic [2:0] sel_o,
  output logic [2:0] ch_o,
  output logic shift_o,
  output logic sdi_o
);
  initial begin
    {start_o, write_o, sel_o, ch_o, shift_o, sdi_o} = '0;
  end
  // Select and channel settle one cycle before start, as the port requires.
  task automatic xfer(input logic wr, input logic [2:0] sel, ch, input logic [23:0] d,
      output logic [23:0] q, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge clk_i);
    write_o <= wr;
    sel_o <= sel;
    ch_o <= ch;
    @(posedge clk_i);
    start_o <= 1'b1;
    @(posedge clk_i);
    start_o <= 1'b0;
    // Idle data shows the inverted bit so a stale value cannot pass for a good one.
    for (int i = 23; i >= 0; i--) begin
      @(negedge clk_i);
      q[i] = sdo_i;
      @(posedge clk_i);
      shift_o <= 1'b1;
      sdi_o <= d[i];
      @(posedge clk_i);
      shift_o <= 1'b0;
      sdi_o <= ~d[i];
    end
    for (n = 0; n < 4 && ok !== 1'b1; n++) begin
      @(negedge clk_i);
      ok = done_i;
    end
  endtask : xfer
endmodule : host_model

// ### tb_top.sv
`timescale 1ns/1ps
// Drives samples, modes and calibration status; the host model runs the frames.
module tb_top;
  logic clk_i, rst_n_i, sv, cv, uni, fmt, rbs, dso, dsg, dxo, dxg, bso, bsg, bsc, cs;
  logic ast, awr, sh, sdi, sdo, adone, rv;
  logic [2:0] sch, css, asel, ach;
  logic [23:0] sd, csd;
  int err_total, checked;
  adc_calibration_correction uut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sample_valid_i(sv),
    .sample_channel_i(sch),
    .sample_data_i(sd),
    .conversion_active_i(cv),
    .unipolar_i(uni),
    .output_format_i(fmt),
    .readback_select_i(rbs),
    .disable_system_offset_i(dso),
    .disable_system_gain_i(dsg),
    .disable_self_offset_i(dxo),
    .disable_self_gain_i(dxg),
    .sys_offset_cal_busy_i(bso),
    .sys_gain_cal_busy_i(bsg),
    .self_cal_busy_i(bsc),
    .cal_store_i(cs),
    .cal_store_sel_i(css),
    .cal_store_data_i(csd),
    .access_start_i(ast),
    .access_write_i(awr),
    .access_sel_i(asel),
    .access_channel_i(ach),
    .shift_i(sh),
    .sdi_i(sdi),
    .sdo_o(sdo),
    .access_done_o(adone),
    .result_valid_o(rv)
  );
  host_model u_host (.clk_i(clk_i), .sdo_i(sdo), .done_i(adone), .start_o(ast),
    .write_o(awr), .sel_o(asel), .ch_o(ach), .shift_o(sh), .sdi_o(sdi));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic close_out;
    $display("checks=%0d errors=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // A frame that never completes ends the run at once.
  task automatic acc(input logic w, input logic [2:0] s, c, input logic [23:0] d,
      output logic [23:0] q);
    logic ok;
    u_host.xfer(w, s, c, d, q, ok);
    if (ok !== 1'b1) begin
      err_total++;
      close_out();
    end
  endtask : acc
  task automatic rdchk(input logic [2:0] s, c, input logic [23:0] ex);
    logic [23:0] q;
    acc(1'b0, s, c, 24'h000000, q);
    chk(q, ex);
  endtask : rdchk
  task automatic wr(input logic [2:0] s, input logic [23:0] d);
    logic [23:0] q;
    acc(1'b1, s, 3'h0, d, q);
  endtask : wr
  task automatic put(input logic [2:0] c, input logic [23:0] d, ex);
    @(posedge clk_i);
    sv <= 1'b1;
    sch <= c;
    sd <= d;
    @(posedge clk_i);
    sv <= 1'b0;
    for (int n = 0; n < 8 && rv !== 1'b1; n++) @(negedge clk_i);
    if (rv !== 1'b1) begin
      err_total++;
      close_out();
    end
    rdchk(cal_pkg::SEL_RESULT, c, ex);
  endtask : put
  task automatic t_reset;
    @(posedge clk_i);
    rbs <= 1'b1;
    rdchk(cal_pkg::SEL_SYS_OFFSET, 3'h0, cal_pkg::SYS_OFFSET_RST);
    rdchk(cal_pkg::SEL_SYS_GAIN, 3'h0, cal_pkg::SYS_GAIN_RST);
    rdchk(cal_pkg::SEL_SELF_OFFSET, 3'h0, cal_pkg::SELF_OFFSET_RST);
    rdchk(cal_pkg::SEL_SELF_GAIN, 3'h0, cal_pkg::SELF_GAIN_RST);
    rdchk(cal_pkg::SEL_RESULT, 3'h5, cal_pkg::RESULT_RST);
  endtask : t_reset
  // Each coefficient takes a write, then refuses one made under its own busy flag.
  task automatic t_busy;
    for (int s = 0; s < 4; s++) begin
      wr(s[2:0], {20'h12345, s[3:0]});
      @(posedge clk_i);
      {bsc, bsg, bso} <= (s == 0) ? 3'h1 : (s == 1) ? 3'h2 : 3'h4;
      wr(s[2:0], 24'hFEDCBA);
      @(posedge clk_i);
      {bsc, bsg, bso} <= 3'h0;
      rdchk(s[2:0], 3'h0, {20'h12345, s[3:0]});
    end
  endtask : t_busy
  task automatic t_internal;
    @(posedge clk_i);
    cv <= 1'b1;
    rbs <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_i);
      cs <= 1'b1;
      css <= s[2:0];
      csd <= {20'hA5A5A, s[3:0]};
      @(posedge clk_i);
      cs <= 1'b0;
      rdchk(s[2:0], 3'h0, {20'hA5A5A, s[3:0]});
    end
    @(posedge clk_i);
    rbs <= 1'b1;
    for (int s = 0; s < 4; s++) rdchk(s[2:0], 3'h0, {20'h12345, s[3:0]});
  endtask : t_internal
  // Mode bits: unipolar, format, then the four skip bits for the correction steps.
  task automatic run_case(input logic [2:0] c, input logic [23:0] raw, so, sg, xo, xg,
      input logic [5:0] m, input logic [23:0] ex);
    wr(cal_pkg::SEL_SYS_OFFSET, so);
    wr(cal_pkg::SEL_SYS_GAIN, sg);
    wr(cal_pkg::SEL_SELF_OFFSET, xo);
    wr(cal_pkg::SEL_SELF_GAIN, xg);
    @(posedge clk_i);
    {uni, fmt, dso, dsg, dxo, dxg} <= m;
    put(c, raw, ex);
  endtask : run_case
  task automatic t_path;
    logic [23:0] u;
    u = 24'h800000;
    run_case(3'h0, 24'h000100, 24'h000010, u, 24'h0, u, 6'h07, 24'h0000F0);
    run_case(3'h1, 24'h000100, 24'h000010, u, 24'h0, u, 6'h0F, 24'h000100);
    run_case(3'h2, 24'h001000, 24'h0, 24'h400000, 24'h0, u, 6'h03, 24'h000800);
    run_case(3'h3, 24'h7FFFFF, 24'hFFFFFF, u, 24'h0, u, 6'h07, 24'h7FFFFF);
    run_case(3'h4, 24'h000000, 24'h0, u, 24'h0, u, 6'h17, 24'h800000);
    run_case(3'h5, 24'h000100, 24'h0, u, 24'h0, u, 6'h27, 24'h800200);
    run_case(3'h0, 24'h000300, 24'h000100, 24'h400000, 24'h0, u, 6'h03, 24'h000100);
    run_case(3'h1, 24'h000300, 24'h0, u, 24'h000100, 24'h400000, 6'h0C, 24'h000100);
    run_case(3'h2, 24'h800000, 24'h000001, u, 24'h0, u, 6'h07, 24'h800000);
    run_case(3'h3, 24'h500000, 24'h0, u, 24'h0, u, 6'h37, 24'hFFFFFF);
  endtask : t_path
  task automatic t_ro;
    wr(cal_pkg::SEL_RESULT, 24'hABCDEF);
    rdchk(cal_pkg::SEL_RESULT, 3'h0, 24'h000100);
  endtask : t_ro
  // A second reset in mid-run must bring back the gain defaults and clear the channel 0 result.
  task automatic t_rst;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdchk(cal_pkg::SEL_SYS_GAIN, 3'h0, cal_pkg::SYS_GAIN_RST);
    rdchk(cal_pkg::SEL_SELF_GAIN, 3'h0, cal_pkg::SELF_GAIN_RST);
    rdchk(cal_pkg::SEL_RESULT, 3'h0, cal_pkg::RESULT_RST);
  endtask : t_rst
  initial begin
    {sv, cv, uni, fmt, rbs, dso, dsg, dxo, dxg, bso, bsg, bsc, cs, sch, css, sd, csd} = '0;
    err_total = 0;
    checked = 0;
    rst_n_i = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_busy();
    t_internal();
    t_path();
    t_ro();
    t_rst();
    close_out();
  end
endmodule : tb_top
